/* pkg/dcc_pkg.sv */
// package: register map, control word layout and decode helpers for the dma channel control block
package dcc_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // register byte addresses
  localparam logic [ADDR_W-1:0] SRC_ADDR_OFS = 12'h100;
  localparam logic [ADDR_W-1:0] DST_ADDR_OFS = 12'h104;
  localparam logic [ADDR_W-1:0] CTRL_OFS = 12'h10C;
  localparam logic [ADDR_W-1:0] CHAN_OFS = 12'h200;

  // channel register bits
  localparam int CHAN_EN_BIT = 0;
  localparam int CHAN_BUSY_BIT = 1;
  localparam int CHAN_WERR_BIT = 2;
  localparam int CHAN_DONE_BIT = 3;

  localparam logic [DATA_W-1:0] CTRL_RST = 32'h0000_0000;
  localparam logic [DATA_W-1:0] ADDR_RST = 32'h0000_0000;

  // item width codes
  localparam logic [2:0] W_BYTE = 3'h0;
  localparam logic [2:0] W_HALF = 3'h1;
  localparam logic [2:0] W_WORD = 3'h2;

  // bus burst type driven on the data masters, independent of burst length
  localparam logic [2:0] HBURST_INCR = 3'h1;

  // control word, msb first
  typedef struct packed {
    logic tc_irq_en;
    logic [2:0] prot;
    logic dst_addr_increment;
    logic src_addr_increment;
    logic dst_master;
    logic src_master;
    logic [2:0] dst_item_width;
    logic [2:0] src_item_width;
    logic [2:0] dst_burst_len;
    logic [2:0] src_burst_len;
    logic [11:0] remaining_transfer_count;
  } dcc_ctrl_t;

  typedef enum logic [2:0] {ST_IDLE, ST_READ, ST_WRITE, ST_END} dcc_state_t;

  // burst length code to number of transfers
  function automatic logic [8:0] burst_beats(input logic [2:0] code);
    case (code)
      3'h0: burst_beats = 9'h001;
      3'h1: burst_beats = 9'h004;
      3'h2: burst_beats = 9'h008;
      3'h3: burst_beats = 9'h010;
      3'h4: burst_beats = 9'h020;
      3'h5: burst_beats = 9'h040;
      3'h6: burst_beats = 9'h080;
      default: burst_beats = 9'h100;
    endcase
  endfunction

  // width code to log2 of bytes; reserved codes fall back to byte
  function automatic logic [1:0] width_log(input logic [2:0] code);
    case (code)
      W_BYTE: width_log = 2'h0;
      W_HALF: width_log = 2'h1;
      W_WORD: width_log = 2'h2;
      default: width_log = 2'h0;
    endcase
  endfunction

  function automatic logic width_reserved(input logic [2:0] code);
    width_reserved = (code != W_BYTE) && (code != W_HALF) && (code != W_WORD);
  endfunction

endpackage

/* pkg/dcc_pack_if.sv */
// interface: engine to packer link for width packing and unpacking
`timescale 1ns/10ps
interface dcc_pack_if;
  logic [1:0] src_log;
  logic [1:0] dst_log;
  logic push;
  logic [31:0] push_data;
  logic pop;
  logic [31:0] pop_data;
  logic clear;
  logic [2:0] reads_per_write;
  logic [2:0] writes_per_read;

  modport engine (output src_log, dst_log, push, push_data, pop, clear,
                  input pop_data, reads_per_write, writes_per_read);
  modport packer (input src_log, dst_log, push, push_data, pop, clear,
                  output pop_data, reads_per_write, writes_per_read);
endinterface

/* rtl/dcc_packer.sv */
// packer: assembles source items into destination items and splits wide items
`timescale 1ns/10ps
module dcc_packer (
  input wire logic ref_clk,
  input wire logic reset_n,
  dcc_pack_if.packer pk
);

  typedef struct packed {
    logic [31:0] buffer;
    logic [2:0] level;
  } dcc_pk_state_t;

  dcc_pk_state_t q;
  dcc_pk_state_t next_q;
  logic [31:0] item_mask;

  // ratio of items between the two sides
  always_comb begin
    if (pk.dst_log > pk.src_log) begin
      pk.reads_per_write = 3'(3'h1 << (pk.dst_log - pk.src_log));
      pk.writes_per_read = 3'h1;
    end else begin
      pk.reads_per_write = 3'h1;
      pk.writes_per_read = 3'(3'h1 << (pk.src_log - pk.dst_log));
    end
  end

  // oldest bytes sit at the bottom of the buffer
  assign pk.pop_data = q.buffer;

  // push appends above the held bytes, pop drops one destination item
  always_comb begin
    next_q = q;
    item_mask = 32'hFFFF_FFFF >> (6'(8) * (6'(3) - 6'((6'(1) << pk.src_log) - 6'(1))));
    if (pk.clear) begin
      next_q.buffer = 32'h0000_0000;
      next_q.level = 3'h0;
    end else if (pk.push) begin
      next_q.buffer = q.buffer | ((pk.push_data & item_mask) << (6'(8) * 6'(q.level)));
      next_q.level = q.level + 3'(3'h1 << pk.src_log);
    end else if (pk.pop) begin
      next_q.buffer = q.buffer >> (6'(8) * 6'(3'h1 << pk.dst_log));
      next_q.level = q.level - 3'(3'h1 << pk.dst_log);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  // a byte source feeding a word sink needs four reads per write
  a_pack_ratio: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (pk.src_log == 2'h0 && pk.dst_log == 2'h2) |-> (pk.reads_per_write == 3'h4))
    else $error("pack ratio wrong");

  // a byte pushed into an empty buffer lands in the bottom byte of the buffer
  a_pack_order: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (pk.push && !pk.clear && q.level == 3'h0 && pk.src_log == 2'h0) |=> (q.buffer[7:0] == $past(pk.push_data[7:0])))
    else $error("packed byte misplaced");

endmodule // dcc_packer

/* rtl/dcc_channel.sv */
// dma channel control word logic: register port, burst pacing, count down and packing control
//
// Summary of operation
// - source select bit routes source reads to master 1 (0) or master 2 (1).
// - differing source and destination widths are packed or unpacked automatically.
// - width codes: 0 byte, 1 halfword, 2 word, others reserved.
// - destination burst field sets transfers per destination burst request.
// - source burst field sets transfers per source burst.
// - burst codes 0..7 give 1,4,8,16,32,64,128,256 transfers.
// - a peripheral burst request moves exactly the programmed burst amount unless the item ends mid-burst, which clears the beats left.
// - bus burst type is independent of the peripheral burst length.
// - writing the 12-bit size field loads the total count for self flow control.
// - the count decrements toward zero, holding transfers remaining.
// - reading the size field gives destination transfers still to complete.
// - increment bits advance source and destination addresses after each transfer.
// - destination select bit routes writes to master 1 (0) or master 2 (1).
// - at packet end while enabled the control word reloads from the next list item.
`timescale 1ns/10ps
module dcc_channel (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic flow_ctrl_is_dmac,
  input wire logic lli_reload_valid,
  input wire logic [31:0] lli_ctrl_word,
  output logic lli_taken,
  input wire logic src_periph_burst_request,
  input wire logic dst_periph_burst_request,
  output logic src_burst_done,
  output logic dst_burst_done,
  output logic src_rd_req,
  output logic [31:0] src_rd_addr,
  output logic src_rd_master,
  output logic [2:0] src_rd_size,
  input wire logic src_rd_ack,
  input wire logic [31:0] src_rd_data,
  output logic dst_wr_req,
  output logic [31:0] dst_wr_addr,
  output logic dst_wr_master,
  output logic [2:0] dst_wr_size,
  output logic [31:0] dst_wr_data,
  input wire logic dst_wr_ack,
  output logic [2:0] bus_burst_type
);

  typedef struct packed {
    dcc_pkg::dcc_state_t state;
    dcc_pkg::dcc_ctrl_t ctrl;
    logic [31:0] src_addr;
    logic [31:0] dst_addr;
    logic enable;
    logic done;
    logic [31:0] rdata;
    logic [8:0] src_beats;
    logic [8:0] dst_beats;
    logic [2:0] rd_left;
    logic [2:0] wr_left;
    logic rd_req;
    logic wr_req;
    logic [31:0] wr_data;
    logic [2:0] rd_size;
    logic [2:0] wr_size;
    logic src_bdone;
    logic dst_bdone;
    logic lli_tk;
    logic [2:0] hburst;
  } dcc_st_t;

  dcc_st_t q;
  dcc_st_t next_q;
  dcc_pack_if pk ();

  logic src_hit;
  logic dst_hit;
  logic count_last;
  logic width_err;
  logic [31:0] chan_word;

  dcc_packer u_packer (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .pk(pk)
  );

  // decoded widths feed the packer
  assign pk.src_log = dcc_pkg::width_log(q.ctrl.src_item_width);
  assign pk.dst_log = dcc_pkg::width_log(q.ctrl.dst_item_width);
  assign pk.push = src_hit;
  assign pk.push_data = src_rd_data;
  assign pk.pop = dst_hit;
  assign pk.clear = (q.state == dcc_pkg::ST_IDLE);

  assign src_hit = (q.state == dcc_pkg::ST_READ) && q.rd_req && src_rd_ack;
  assign dst_hit = (q.state == dcc_pkg::ST_WRITE) && q.wr_req && dst_wr_ack;
  // only the controller as flow controller counts; otherwise the field is ignored
  assign count_last = flow_ctrl_is_dmac && (q.ctrl.remaining_transfer_count == 12'h001);
  assign width_err = dcc_pkg::width_reserved(q.ctrl.src_item_width) |
                     dcc_pkg::width_reserved(q.ctrl.dst_item_width);

  always_comb begin
    chan_word = 32'h0000_0000;
    chan_word[dcc_pkg::CHAN_EN_BIT] = q.enable;
    chan_word[dcc_pkg::CHAN_BUSY_BIT] = (q.state != dcc_pkg::ST_IDLE);
    chan_word[dcc_pkg::CHAN_WERR_BIT] = width_err;
    chan_word[dcc_pkg::CHAN_DONE_BIT] = q.done;
  end

  // outputs straight from the state flops
  assign reg_rdata = q.rdata;
  assign lli_taken = q.lli_tk;
  assign src_burst_done = q.src_bdone;
  assign dst_burst_done = q.dst_bdone;
  assign src_rd_req = q.rd_req;
  assign src_rd_addr = q.src_addr;
  assign src_rd_master = q.ctrl.src_master;
  assign src_rd_size = q.rd_size;
  assign dst_wr_req = q.wr_req;
  assign dst_wr_addr = q.dst_addr;
  assign dst_wr_master = q.ctrl.dst_master;
  assign dst_wr_size = q.wr_size;
  assign dst_wr_data = q.wr_data;
  assign bus_burst_type = q.hburst;

  // register port, then the transfer engine; engine updates come last and win
  always_comb begin
    next_q = q;
    next_q.src_bdone = 1'b0;
    next_q.dst_bdone = 1'b0;
    next_q.lli_tk = 1'b0;
    // fixed bus burst type whatever the burst length fields hold
    next_q.hburst = dcc_pkg::HBURST_INCR;

    // read data valid in the cycle after the strobe; size field reads live count
    if (reg_rd) begin
      case (reg_addr)
        dcc_pkg::SRC_ADDR_OFS: next_q.rdata = q.src_addr;
        dcc_pkg::DST_ADDR_OFS: next_q.rdata = q.dst_addr;
        dcc_pkg::CTRL_OFS: next_q.rdata = q.ctrl;
        dcc_pkg::CHAN_OFS: next_q.rdata = chan_word;
        default: next_q.rdata = 32'h0000_0000;
      endcase
    end

    if (reg_wr) begin
      case (reg_addr)
        dcc_pkg::SRC_ADDR_OFS: next_q.src_addr = reg_wdata;
        dcc_pkg::DST_ADDR_OFS: next_q.dst_addr = reg_wdata;
        dcc_pkg::CTRL_OFS: next_q.ctrl = reg_wdata;
        dcc_pkg::CHAN_OFS: begin
          next_q.enable = reg_wdata[dcc_pkg::CHAN_EN_BIT];
          if (reg_wdata[dcc_pkg::CHAN_EN_BIT]) begin
            next_q.done = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    case (q.state)
      dcc_pkg::ST_IDLE: begin
        if (q.enable && !(flow_ctrl_is_dmac && q.ctrl.remaining_transfer_count == 12'h000)) begin
          next_q.state = dcc_pkg::ST_READ;
          next_q.rd_left = pk.reads_per_write;
        end
      end
      dcc_pkg::ST_READ: begin
        if (!q.rd_req) begin
          if (!q.enable) begin
            next_q.state = dcc_pkg::ST_IDLE;
          end else if (q.src_beats != 9'h000) begin
            next_q.rd_req = 1'b1;
            next_q.rd_size = q.ctrl.src_item_width;
          end else if (src_periph_burst_request) begin
            // a new burst only on request, exactly the programmed length
            next_q.src_beats = dcc_pkg::burst_beats(q.ctrl.src_burst_len);
          end
        end else if (src_rd_ack) begin
          next_q.rd_req = 1'b0;
          next_q.src_beats = q.src_beats - 9'h001;
          next_q.src_bdone = (q.src_beats == 9'h001);
          if (q.ctrl.src_addr_increment) begin
            next_q.src_addr = q.src_addr + (32'h0000_0001 << pk.src_log);
          end
          next_q.rd_left = q.rd_left - 3'h1;
          if (q.rd_left == 3'h1) begin
            next_q.state = dcc_pkg::ST_WRITE;
            next_q.wr_left = pk.writes_per_read;
          end
        end
      end
      dcc_pkg::ST_WRITE: begin
        if (!q.wr_req) begin
          if (!q.enable) begin
            next_q.state = dcc_pkg::ST_IDLE;
          end else if (q.dst_beats != 9'h000) begin
            next_q.wr_req = 1'b1;
            next_q.wr_data = pk.pop_data;
            next_q.wr_size = q.ctrl.dst_item_width;
          end else if (dst_periph_burst_request) begin
            next_q.dst_beats = dcc_pkg::burst_beats(q.ctrl.dst_burst_len);
          end
        end else if (dst_wr_ack) begin
          next_q.wr_req = 1'b0;
          next_q.dst_beats = q.dst_beats - 9'h001;
          next_q.dst_bdone = (q.dst_beats == 9'h001);
          if (q.ctrl.dst_addr_increment) begin
            next_q.dst_addr = q.dst_addr + (32'h0000_0001 << pk.dst_log);
          end
          if (flow_ctrl_is_dmac) begin
            // one per destination item, counting toward zero
            next_q.ctrl.remaining_transfer_count = q.ctrl.remaining_transfer_count - 12'h001;
          end
          next_q.wr_left = q.wr_left - 3'h1;
          if (count_last) begin
            next_q.state = dcc_pkg::ST_END;
          end else if (q.wr_left == 3'h1) begin
            next_q.state = dcc_pkg::ST_READ;
            next_q.rd_left = pk.reads_per_write;
          end
        end
      end
      dcc_pkg::ST_END: begin
        // a pending list item keeps the channel going, else it stops
        if (q.enable && lli_reload_valid) begin
          next_q.ctrl = lli_ctrl_word;
          next_q.lli_tk = 1'b1;
        end else begin
          next_q.enable = 1'b0;
          next_q.done = 1'b1;
        end
        next_q.src_beats = 9'h000;
        next_q.dst_beats = 9'h000;
        next_q.state = dcc_pkg::ST_IDLE;
      end
      default: next_q.state = dcc_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      q <= '0;
      q.state <= dcc_pkg::ST_IDLE;
      q.ctrl <= dcc_pkg::CTRL_RST;
      q.src_addr <= dcc_pkg::ADDR_RST;
      q.dst_addr <= dcc_pkg::ADDR_RST;
      q.hburst <= dcc_pkg::HBURST_INCR;
    end else begin
      q <= next_q;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  sequence s_dst_beat;
    dst_wr_req && dst_wr_ack && q.state == dcc_pkg::ST_WRITE;
  endsequence

  sequence s_src_start;
    q.state == dcc_pkg::ST_READ && !src_rd_req && q.enable && q.src_beats == 9'h000 && src_periph_burst_request;
  endsequence

  a_src_route: assert property (src_rd_req |-> src_rd_master == q.ctrl.src_master)
    else $error("source master select not honoured");

  a_dst_route: assert property (dst_wr_req |-> dst_wr_master == q.ctrl.dst_master)
    else $error("destination master select not honoured");

  a_count_down: assert property (s_dst_beat ##0 flow_ctrl_is_dmac ##0 (q.ctrl.remaining_transfer_count != 12'h000)
    |=> q.ctrl.remaining_transfer_count == $past(q.ctrl.remaining_transfer_count) - 12'h001)
    else $error("count did not drop by one");

  a_count_end: assert property (s_dst_beat ##0 count_last |=> q.state == dcc_pkg::ST_END ##1 q.state == dcc_pkg::ST_IDLE)
    else $error("item did not end at zero");

  a_src_burst_len: assert property (s_src_start ##0 (q.ctrl.src_burst_len == 3'h1) |=> q.src_beats == 9'h004)
    else $error("source burst length decode wrong");

  // beats load one cycle after the request, the read strobe rises a cycle later; a disable write sends the channel idle with the beats kept
  a_burst_exact: assert property (s_src_start ##0 !reg_wr |=>
    q.src_beats == dcc_pkg::burst_beats(q.ctrl.src_burst_len) ##1 src_rd_req)
    else $error("burst amount not loaded");

  a_bus_burst: assert property (##1 bus_burst_type == dcc_pkg::HBURST_INCR)
    else $error("bus burst type follows burst length");

  a_size_read: assert property (reg_rd && reg_addr == dcc_pkg::CTRL_OFS && !reg_wr && q.state == dcc_pkg::ST_IDLE
    |=> reg_rdata[11:0] == $past(q.ctrl.remaining_transfer_count))
    else $error("size field read mismatch");

  a_lli_reload: assert property (q.state == dcc_pkg::ST_END && q.enable && lli_reload_valid
    |=> lli_taken && q.ctrl == $past(lli_ctrl_word))
    else $error("control word not reloaded");

  a_dst_addr_inc: assert property (s_dst_beat ##0 q.ctrl.dst_addr_increment && !reg_wr
    |=> dst_wr_addr == $past(dst_wr_addr) + (32'h0000_0001 << $past(pk.dst_log)))
    else $error("destination address did not advance");

endmodule // dcc_channel

/* tb/dcc_partner.sv */
// partner model: source and destination bus slaves plus the two bursting peripherals
`timescale 1ns/10ps
module dcc_partner (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic run,
  input wire logic src_rd_req,
  input wire logic [31:0] src_rd_addr,
  output logic src_rd_ack,
  output logic [31:0] src_rd_data,
  input wire logic dst_wr_req,
  output logic dst_wr_ack,
  output logic src_periph_burst_request,
  output logic dst_periph_burst_request
);
  integer seed = 34490;
  int src_wait = 0;
  int dst_wait = 0;
  logic [31:0] r;

  // source image depends on address so a wrong read address shows in the data
  function automatic logic [7:0] mem_byte(input logic [31:0] a);
    return a[7:0] ^ a[15:8] ^ 8'hA5;
  endfunction

  // slaves answer after zero to three wait cycles; idle read data churns so stale data is never right
  always @(posedge ref_clk) begin
    r = $random(seed);
    src_periph_burst_request <= run & r[0];
    dst_periph_burst_request <= run & r[1];
    if (reset_n && src_rd_req && !src_rd_ack && src_wait >= int'(r[3:2])) begin
      src_rd_ack <= 1'b1;
      src_rd_data <= {mem_byte(src_rd_addr + 32'h3), mem_byte(src_rd_addr + 32'h2),
                      mem_byte(src_rd_addr + 32'h1), mem_byte(src_rd_addr)};
      src_wait = 0;
    end else begin
      src_rd_ack <= 1'b0;
      src_rd_data <= r;
      src_wait = (src_rd_req && !src_rd_ack) ? src_wait + 1 : 0;
    end
    if (reset_n && dst_wr_req && !dst_wr_ack && dst_wait >= int'(r[5:4])) begin
      dst_wr_ack <= 1'b1;
      dst_wait = 0;
    end else begin
      dst_wr_ack <= 1'b0;
      dst_wait = (dst_wr_req && !dst_wr_ack) ? dst_wait + 1 : 0;
    end
  end
endmodule // dcc_partner

/* tb/tb.sv */
// testbench: programs the channel, runs transfers against the partner and checks results from queues
`timescale 1ns/10ps
module tb;
  logic ref_clk, reset_n, reg_wr, reg_rd, run, flow_ctrl_is_dmac, lli_reload_valid, lli_taken;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, lli_ctrl_word, src_rd_addr, src_rd_data, dst_wr_addr, dst_wr_data;
  logic src_periph_burst_request, dst_periph_burst_request, src_burst_done, dst_burst_done;
  logic src_rd_req, src_rd_master, src_rd_ack, dst_wr_req, dst_wr_master, dst_wr_ack;
  logic [2:0] src_rd_size, dst_wr_size, bus_burst_type;
  integer seed = 34490;
  int err_count = 0;
  int total_checks = 0;
  int src_beats = 0;
  int dst_beats = 0;
  int reads = 0;
  int reloads = 0;
  logic [31:0] rq[$];
  logic [63:0] wq[$];
  logic [63:0] w;
  logic rd_pend = 1'b0;
  logic [31:0] src_base, dst_base, c_mask;
  logic [2:0] c_sw, c_dw, c_sbl, c_dbl;
  logic c_sm, c_dm, c_si, c_di;

  dcc_channel dcc_channel_i (.ref_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .flow_ctrl_is_dmac, .lli_reload_valid, .lli_ctrl_word, .lli_taken, .src_periph_burst_request,
    .dst_periph_burst_request, .src_burst_done, .dst_burst_done, .src_rd_req, .src_rd_addr, .src_rd_master,
    .src_rd_size, .src_rd_ack, .src_rd_data, .dst_wr_req, .dst_wr_addr, .dst_wr_master, .dst_wr_size,
    .dst_wr_data, .dst_wr_ack, .bus_burst_type);
  dcc_partner dcc_partner_i (.ref_clk, .reset_n, .run, .src_rd_req, .src_rd_addr, .src_rd_ack, .src_rd_data,
    .dst_wr_req, .dst_wr_ack, .src_periph_burst_request, .dst_periph_burst_request);

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  function automatic logic [7:0] mem_byte(input logic [31:0] a);
    return a[7:0] ^ a[15:8] ^ 8'hA5;
  endfunction
  // reserved width codes move bytes
  function automatic int bytes_of(input logic [2:0] c);
    return (c == 3'h1) ? 2 : (c == 3'h2) ? 4 : 1;
  endfunction
  function automatic int beats_of(input logic [2:0] c);
    return (c == 3'h0) ? 1 : (1 << (int'(c) + 1));
  endfunction

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // bus tasks leave the strobe up; bus_idle drops it, so back to back accesses never glitch
  task automatic reg_write(input logic [11:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic reg_read(input logic [11:0] a, input logic [31:0] exp);
    rq.push_back(exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic bus_idle();
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    @(posedge ref_clk);
  endtask

  // widths stay within the 32-bit masters, burst fields match the partner's pacing
  task automatic run_xfer(input logic [2:0] sw, dw, sbl, dbl, input int n, n2);
    logic [31:0] ctrl, d, r;
    int sb, db, i, j, x;
    // with a peripheral as flow controller the channel never ends: keep spare items, stop it by disable
    x = flow_ctrl_is_dmac ? 0 : 4;
    sb = bytes_of(sw);
    db = bytes_of(dw);
    r = $random(seed);
    {c_sm, c_dm, c_si, c_di} = r[3:0];
    src_base = $random(seed) & 32'h00FF_FFF0;
    dst_base = $random(seed) & 32'h00FF_FFF0;
    {c_sw, c_dw, c_sbl, c_dbl} = {sw, dw, sbl, dbl};
    c_mask = (dw == 3'h2) ? 32'hFFFF_FFFF : (dw == 3'h1) ? 32'h0000_FFFF : 32'h0000_00FF;
    reads = 0;
    src_beats = 0;
    dst_beats = 0;
    ctrl = {4'h0, c_di, c_si, c_dm, c_sm, dw, sw, dbl, sbl, 12'((x > 0) ? 0 : n)};
    // byte stream of the source, regrouped into destination items low byte first
    for (int k = 0; k < n + n2 + x; k++) begin
      d = 32'h0000_0000;
      for (j = 0; j < db; j++) begin
        i = k * db + j;
        d[8*j +: 8] = mem_byte(src_base + (c_si ? (i / sb) * sb : 0) + (i % sb));
      end
      wq.push_back({dst_base + (c_di ? k * db : 0), d});
    end
    lli_ctrl_word <= {ctrl[31:12], 12'(n2)};
    lli_reload_valid <= (n2 > 0);
    reg_write(dcc_pkg::SRC_ADDR_OFS, src_base);
    reg_write(dcc_pkg::DST_ADDR_OFS, dst_base);
    reg_write(dcc_pkg::CTRL_OFS, ctrl);
    reg_read(dcc_pkg::CTRL_OFS, ctrl);
    reg_write(dcc_pkg::CHAN_OFS, 32'h0000_0001);
    bus_idle();
    run <= 1'b1;
    // the list item is offered until the channel takes it once
    for (j = 0; j < 20000 && wq.size() > x; j++) begin
      @(posedge ref_clk);
      if (lli_taken) lli_reload_valid <= 1'b0;
    end
    check("pending_writes", wq.size(), x);
    if (x > 0) reg_write(dcc_pkg::CHAN_OFS, 32'h0000_0000);
    bus_idle();
    run <= 1'b0;
    repeat (8) @(posedge ref_clk);
    // items really written; a disabled channel leaves the rest unsent
    i = n + n2 + x - wq.size();
    wq.delete();
    // read back only once the channel has stopped
    reg_read(dcc_pkg::CTRL_OFS, {ctrl[31:12], 12'h000});
    reg_read(dcc_pkg::CHAN_OFS, {28'h0, x == 0, (sw > 3'h2) || (dw > 3'h2), 2'b00});
    reg_read(dcc_pkg::SRC_ADDR_OFS, src_base + (c_si ? ((x > 0) ? reads * sb : (n + n2) * db) : 0));
    reg_read(dcc_pkg::DST_ADDR_OFS, dst_base + (c_di ? i * db : 0));
    reg_read(12'h300, 32'h0000_0000);
    bus_idle();
  endtask

  // result monitor: takes the oldest note whenever a read answer or a write appears
  always @(posedge ref_clk) begin
    if (rd_pend) check("reg_rdata", reg_rdata, rq.pop_front());
    rd_pend <= reg_rd;
    if (src_rd_req && src_rd_ack) begin
      check("src_rd_addr", src_rd_addr, src_base + (c_si ? reads * bytes_of(c_sw) : 0));
      check("src_rd_master", {31'h0, src_rd_master}, {31'h0, c_sm});
      if (c_sw < 3'h3) check("src_rd_size", {29'h0, src_rd_size}, {29'h0, c_sw});
      reads++;
      src_beats++;
    end
    if (dst_wr_req && dst_wr_ack) begin
      w = (wq.size() > 0) ? wq.pop_front() : 'x;
      check("dst_wr_addr", dst_wr_addr, w[63:32]);
      check("dst_wr_data", dst_wr_data & c_mask, w[31:0]);
      check("dst_wr_master", {31'h0, dst_wr_master}, {31'h0, c_dm});
      check("dst_wr_size", {29'h0, dst_wr_size}, {29'h0, c_dw});
      check("bus_burst_type", {29'h0, bus_burst_type}, {29'h0, dcc_pkg::HBURST_INCR});
      dst_beats++;
    end
    if (src_burst_done) begin
      check("src_burst_len", src_beats, beats_of(c_sbl));
      src_beats = 0;
    end
    if (dst_burst_done) begin
      check("dst_burst_len", dst_beats, beats_of(c_dbl));
      dst_beats = 0;
    end
    if (lli_taken) begin
      reloads++;
    end
  end

  initial begin
    repeat (100000) @(posedge ref_clk);
    err_count++;
    stop_test();
  end

  initial begin
    reset_n = 1'b0;
    {reg_wr, reg_rd, run, lli_reload_valid} = 4'h0;
    flow_ctrl_is_dmac = 1'b1;
    reg_addr = 12'h000;
    reg_wdata = 32'h0000_0000;
    lli_ctrl_word = 32'h0000_0000;
    repeat (3) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    reg_read(dcc_pkg::CTRL_OFS, dcc_pkg::CTRL_RST);
    reg_read(dcc_pkg::SRC_ADDR_OFS, dcc_pkg::ADDR_RST);
    reg_read(dcc_pkg::CHAN_OFS, 32'h0000_0000);
    bus_idle();
    // every burst length code, one full burst each side
    for (int c = 0; c < 8; c++) run_xfer(3'h0, 3'h0, 3'(c), 3'(c), beats_of(3'(c)), 0);
    // every width pairing, packing and unpacking
    for (int s = 0; s < 3; s++) begin
      for (int d = 0; d < 3; d++) run_xfer(3'(s), 3'(d), 3'h0, 3'h0, 4, 0);
    end
    run_xfer(3'h5, 3'h0, 3'h0, 3'h0, 3, 0);
    // second list item picked up at the end of the first
    run_xfer(3'h1, 3'h2, 3'h1, 3'h0, 2, 2);
    check("reloads", reloads, 1);
    // peripheral as flow controller: a zero count stays frozen until software disables
    flow_ctrl_is_dmac <= 1'b0;
    bus_idle();
    run_xfer(3'h0, 3'h0, 3'h0, 3'h0, 8, 0);
    stop_test();
  end
endmodule // tb
